/* File: include/rsc_pkg.sv */
// Purpose: shared constants and types for reset strap capture
// Assumes: mclk at 250 MHz, strap vector ordered as listed below
// Notes:   timing counts derive from printed times and clock period
package rsc_pkg;

  localparam int CLK_PERIOD_NS = 4;
  // board reset hold times
  localparam int POR_HOLD_NS   = 100000;
  localparam int POR_HOLD_CYC  = (POR_HOLD_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int RST_HOLD_NS   = 10000;
  localparam int RST_HOLD_CYC  = (RST_HOLD_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  // 25 MHz reference period; output clock half period in mclk cycles
  localparam int REF_PERIOD_NS   = 40;
  localparam int CLKOUT_HALF_CYC = REF_PERIOD_NS / (2 * CLK_PERIOD_NS);

  // strap vector bit positions
  localparam int STRAP_W  = 8;
  localparam int IDX_T0   = 0;
  localparam int IDX_T1   = 1;
  localparam int IDX_T2   = 2;
  localparam int IDX_T3   = 3;
  localparam int IDX_SS   = 4;
  localparam int IDX_SIO0 = 5;
  localparam int IDX_SIO2 = 7;
  localparam int NUM_TMR  = 4;

  // internal pull levels: timer 0/1 and spi select up, rest down
  localparam logic [STRAP_W-1:0] STRAP_PULL_DEFAULT = 8'h13;
  localparam logic [2:0]         PORT_CODE_MAX      = 3'h5;
  localparam logic [1:0]         SPI_TMR_CODE       = 2'h3;
  // timer pins able to carry 1588 outputs and input captures
  localparam logic [NUM_TMR-1:0] PTP_PIN_MASK       = 4'hC;

  typedef enum logic [1:0] {
    SPI_SINGLE = 2'h0,
    SPI_DUAL   = 2'h1,
    SPI_QUAD   = 2'h2,
    SPI_NONE   = 2'h3
  } rsc_spi_mode_t;

  typedef enum logic [2:0] {
    TFN_OFF     = 3'h0,
    TFN_TSN     = 3'h1,
    TFN_LEGACY  = 3'h2,
    TFN_PTP     = 3'h3,
    TFN_CAPTURE = 3'h4,
    TFN_GPIO    = 3'h5,
    TFN_IRQ     = 3'h6
  } rsc_tfn_t;

endpackage

/* File: include/rsc_link_if.sv */
// Purpose: board-to-device pins: reset, strap pins, clock output
// Assumes: strong device drive beats strap resistors, which beat pulls
// Notes:   wire levels resolved here from the output enables
`timescale 1ns/10ps
`default_nettype none
interface rsc_link_if;
  import rsc_pkg::*;

  logic               reset_pin_n;  // board reset driver, active low
  logic [NUM_TMR-1:0] tmr_dev_o;    // device drive of timer pins
  logic [NUM_TMR-1:0] tmr_dev_oe;   // device enable of timer pins
  logic [STRAP_W-1:0] brd_strap_o;  // external resistor level
  logic [STRAP_W-1:0] brd_strap_oe; // resistor fitted
  logic               clk_out;      // 25 MHz output clock
  logic               clk_out_oe;   // clock output enable
  logic [STRAP_W-1:0] strap_lvl;    // resolved pin levels

  // resistor or pull first, device drive then overrides the timer pins;
  // two loops keep every index inside its own vector
  always_comb begin
    for (int i = 0; i < STRAP_W; i++) begin
      if (brd_strap_oe[i]) begin
        strap_lvl[i] = brd_strap_o[i];
      end else begin
        strap_lvl[i] = STRAP_PULL_DEFAULT[i];
      end
    end
    for (int j = 0; j < NUM_TMR; j++) begin
      if (tmr_dev_oe[j]) begin
        strap_lvl[j] = tmr_dev_o[j];
      end
    end
  end

  modport dev (input reset_pin_n, strap_lvl,
               output tmr_dev_o, tmr_dev_oe, clk_out, clk_out_oe);
  modport brd (output reset_pin_n, brd_strap_o, brd_strap_oe,
               input strap_lvl, clk_out, clk_out_oe);
endinterface
`default_nettype wire

/* File: hw/rsc_clk_div.sv */
// Purpose: divides mclk down to the 25 MHz output clock
// Assumes: run low holds the output low and restarts the phase
// Notes:   output toggles every CLKOUT_HALF_CYC cycles
`timescale 1ns/10ps
`default_nettype none
module rsc_clk_div
  import rsc_pkg::*;
(
  input  wire logic mclk,   // system clock
  input  wire logic arst_n, // async reset
  input  wire logic run,    // divider enable level
  output var  logic clk_q   // divided clock
);
  localparam logic [3:0] HALF_M1 = 4'(CLKOUT_HALF_CYC - 1);
  logic [3:0] cnt_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 4'h0;
      clk_q <= 1'b0;
    end else if (!run) begin
      cnt_q <= 4'h0;
      clk_q <= 1'b0;
    end else if (cnt_q == HALF_M1) begin
      cnt_q <= 4'h0;
      clk_q <= ~clk_q;
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule // rsc_clk_div
`default_nettype wire

/* File: hw/rsc_device.sv */
// Purpose: device end: strap capture, host decode, timer pins, clock out
// Assumes: link pins synchronous to mclk; board honours hold times
// Notes:   configuration outputs valid only while cfg_valid_q is high
// Functional notes
// - straps sio2..0 give port 0-5, 6-7 reserved
// - SPI host: no port, ds from strap
// - drive strength one is high, zero low
// - no resistors fitted gives single SPI host
// - pull defaults: timers 1,1,0,0, select 1, sio 0
// - latch all straps at reset pin release
// - board keeps straps static during the latch
// - board holds reset 100 us after power up
// - board runtime reset pulse at least 10 us
// - every output pin tri-stated while reset low
// - timer zero doubles as SPI interrupt
// - TSN, legacy on all; 1588, capture on 2,3
// - timer pins 0-3 become general io 4-7
// - 25 MHz clock output from reference
// - RGMII delay at one stage, strap adds both
// - second host interface only after first contact
// - straps report host location and protocol
`timescale 1ns/10ps
`default_nettype none
module rsc_device
  import rsc_pkg::*;
(
  input  wire logic               mclk,          // 250 MHz clock
  input  wire logic               arst_n,        // async reset
  rsc_link_if.dev                 link,          // board pins
  input  wire logic [NUM_TMR-1:0][2:0] tmr_fn,   // per pin function
  input  wire logic [NUM_TMR-1:0] tsn_out,       // tsn timer outputs
  input  wire logic [NUM_TMR-1:0] legacy_out,    // legacy timer outputs
  input  wire logic [1:0]         ptp_out,       // 1588 outputs pins 2,3
  input  wire logic               spi_irq,       // SPI host interrupt
  input  wire logic [NUM_TMR-1:0] gpio_out,      // general io drive
  input  wire logic [NUM_TMR-1:0] gpio_oe,       // general io enable
  input  wire logic               sec_host_req,  // second host request
  output var  logic               cfg_valid_q,   // straps latched
  output var  logic               host_is_spi_q, // SPI host protocol
  output var  rsc_spi_mode_t      spi_mode_q,    // SPI width
  output var  logic [2:0]         host_port_q,   // ethernet host port
  output var  logic               port_valid_q,  // port selected
  output var  logic               cfg_invalid_q, // reserved code
  output var  logic               drive_high_q,  // host drive strength
  output var  logic [3:0]         iface_code_q,  // timer strap code
  output var  logic               rx_delay_q,    // device rx delay
  output var  logic               tx_delay_q,    // device tx delay
  output var  logic               sec_host_on_q, // data host enabled
  output logic      [1:0]         capture_evt,   // capture pulses
  output var  logic [NUM_TMR-1:0] general_io_in_q // general io 4-7
);
  typedef enum logic [1:0] {
    DEV_RESET = 2'b01,
    DEV_RUN   = 2'b10
  } rsc_dev_st_t;

  rsc_dev_st_t        st_q;
  logic               run;
  logic               rise;
  logic [STRAP_W-1:0] s;
  logic [3:0]         t;
  logic [2:0]         sio;
  logic               d_spi;
  logic               d_ds;
  rsc_spi_mode_t      d_mode;
  logic [NUM_TMR-1:0] tmr_o_q;
  logic [NUM_TMR-1:0] tmr_oe_q;
  logic [NUM_TMR-1:0] lvl_q;
  logic [NUM_TMR-1:0] cap_q;
  logic [NUM_TMR-1:0] ptp_ext;
  logic               clk_div;
  logic               clk_oe_q;

  assign run  = link.reset_pin_n;
  // first high cycle after a low; timer enables are still off here
  assign rise = run && (st_q == DEV_RESET);
  assign s    = link.strap_lvl;
  assign t    = s[IDX_T3:IDX_T0];
  assign sio  = s[IDX_SIO2:IDX_SIO0];
  assign ptp_ext = {ptp_out, 2'b00};

  // spi iff select strap high and timer 1:0 both high
  always_comb begin
    d_spi = s[IDX_SS] && (t[1:0] == SPI_TMR_CODE);
    if (!d_spi) begin
      d_mode = SPI_NONE;
    end else if (t[IDX_T2]) begin
      d_mode = SPI_QUAD;
    end else if (t[IDX_T3]) begin
      d_mode = SPI_DUAL;
    end else begin
      d_mode = SPI_SINGLE;
    end
    if (d_mode == SPI_QUAD) begin
      d_ds = t[IDX_T3];
    end else if (d_spi) begin
      d_ds = sio[2];
    end else begin
      d_ds = s[IDX_SS];
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= DEV_RESET;
    end else if (!run) begin
      st_q <= DEV_RESET;
    end else begin
      st_q <= DEV_RUN;
    end
  end

  // configuration held from one release to the next; only cfg_valid_q drops at reset assertion
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_valid_q   <= 1'b0;
      host_is_spi_q <= 1'b0;
      spi_mode_q    <= SPI_NONE;
      host_port_q   <= 3'h0;
      port_valid_q  <= 1'b0;
      cfg_invalid_q <= 1'b0;
      drive_high_q  <= 1'b0;
      iface_code_q  <= 4'h0;
      rx_delay_q    <= 1'b0;
      tx_delay_q    <= 1'b0;
    end else if (!run) begin
      cfg_valid_q   <= 1'b0;
    end else if (rise) begin
      cfg_valid_q   <= 1'b1;
      host_is_spi_q <= d_spi;
      spi_mode_q    <= d_mode;
      host_port_q   <= d_spi ? 3'h0 : sio;
      port_valid_q  <= !d_spi && (sio <= PORT_CODE_MAX);
      cfg_invalid_q <= !d_spi && (sio > PORT_CODE_MAX);
      drive_high_q  <= d_ds;
      iface_code_q  <= t;
      // rgmii delay: one stage each way unless strap asks for both
      rx_delay_q    <= !d_spi && t[0] && !t[1];
      tx_delay_q    <= !d_spi && ((t[1] && !t[0] && !t[2])
                                  || (t[2] && t[0] && !t[1]));
    end
  end

  // data host only after the strapped link is up
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sec_host_on_q <= 1'b0;
    end else begin
      sec_host_on_q <= run && cfg_valid_q && sec_host_req;
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_TMR; g++) begin : g_tmr
      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          tmr_o_q[g]  <= 1'b0;
          tmr_oe_q[g] <= 1'b0;
        end else if (!run) begin
          tmr_o_q[g]  <= 1'b0;
          tmr_oe_q[g] <= 1'b0;
        end else begin
          unique case (tmr_fn[g])
            TFN_TSN: begin
              tmr_o_q[g]  <= tsn_out[g];
              tmr_oe_q[g] <= 1'b1;
            end
            TFN_LEGACY: begin
              tmr_o_q[g]  <= legacy_out[g];
              tmr_oe_q[g] <= 1'b1;
            end
            TFN_PTP: begin
              tmr_o_q[g]  <= ptp_ext[g];
              tmr_oe_q[g] <= PTP_PIN_MASK[g];
            end
            TFN_GPIO: begin
              tmr_o_q[g]  <= gpio_out[g];
              tmr_oe_q[g] <= gpio_oe[g];
            end
            TFN_IRQ: begin
              tmr_o_q[g]  <= spi_irq;
              tmr_oe_q[g] <= (g == 0) && host_is_spi_q;
            end
            default: begin
              tmr_o_q[g]  <= 1'b0;
              tmr_oe_q[g] <= 1'b0;
            end
          endcase
        end
      end

      always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
          lvl_q[g]           <= 1'b0;
          cap_q[g]           <= 1'b0;
          general_io_in_q[g] <= 1'b0;
        end else begin
          lvl_q[g] <= s[g];
          cap_q[g] <= run && PTP_PIN_MASK[g]
                      && (tmr_fn[g] == TFN_CAPTURE) && s[g] && !lvl_q[g];
          general_io_in_q[g] <= run && (tmr_fn[g] == TFN_GPIO)
                                && s[g];
        end
      end
    end
  endgenerate

  assign capture_evt = cap_q[3:2];

  rsc_clk_div u_clk_div (
    .mclk   (mclk),
    .arst_n (arst_n),
    .run    (run),
    .clk_q  (clk_div)
  );

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      clk_oe_q <= 1'b0;
    end else begin
      clk_oe_q <= run;
    end
  end

  assign link.tmr_dev_o  = tmr_o_q;
  assign link.tmr_dev_oe = tmr_oe_q;
  assign link.clk_out    = clk_div;
  assign link.clk_out_oe = clk_oe_q;

endmodule // rsc_device
`default_nettype wire

/* File: hw/rsc_board.sv */
// Purpose: board end: reset driver and external strap resistors
// Assumes: strap choice only sampled from user side while in reset
// Notes:   power-on hold is a parameter so simulation can shorten it
`timescale 1ns/10ps
`default_nettype none
module rsc_board
  import rsc_pkg::*;
#(
  parameter int POR_CYC = POR_HOLD_CYC  // power-on hold cycles
)
(
  input  wire logic               mclk,      // 250 MHz clock
  input  wire logic               arst_n,    // async reset, power-on
  rsc_link_if.brd                 link,      // device pins
  input  wire logic               reset_req, // runtime reset pulse
  input  wire logic [STRAP_W-1:0] strap_fit, // resistor fitted per pin
  input  wire logic [STRAP_W-1:0] strap_val, // resistor level per pin
  output var  logic               in_reset_q // reset pin held low
);
  typedef enum logic [2:0] {
    BRD_POWER = 3'b001,
    BRD_RUN   = 3'b010,
    BRD_RESET = 3'b100
  } rsc_brd_st_t;

  localparam logic [31:0] POR_LAST = 32'(POR_CYC - 1);
  localparam logic [31:0] RST_LAST = 32'(RST_HOLD_CYC - 1);

  rsc_brd_st_t        st_q;
  logic [31:0]        cnt_q;
  logic               pin_q;
  logic [STRAP_W-1:0] fit_q;
  logic [STRAP_W-1:0] val_q;

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_q  <= BRD_POWER;
      cnt_q <= 32'h0;
      pin_q <= 1'b0;
    end else begin
      unique case (st_q)
        BRD_POWER: begin
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q == POR_LAST) begin
            st_q  <= BRD_RUN;
            pin_q <= 1'b1;
          end
        end
        BRD_RUN: begin
          cnt_q <= 32'h0;
          if (reset_req) begin
            st_q  <= BRD_RESET;
            pin_q <= 1'b0;
          end
        end
        BRD_RESET: begin
          cnt_q <= cnt_q + 32'h1;
          if (cnt_q == RST_LAST) begin
            st_q  <= BRD_RUN;
            pin_q <= 1'b1;
          end
        end
      endcase
    end
  end

  // strap choice frozen before release so pins are static at the latch
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fit_q <= 8'h00;
      val_q <= 8'h00;
    end else if (!pin_q) begin
      fit_q <= strap_fit;
      val_q <= strap_val;
    end
  end

  assign in_reset_q        = ~pin_q;
  assign link.reset_pin_n  = pin_q;
  assign link.brd_strap_o  = val_q;
  assign link.brd_strap_oe = fit_q;

endmodule // rsc_board
`default_nettype wire

/* File: test/rsc_link_chk.sv */
// Purpose: wire checks on the board to device link of strap capture
// Assumes: one mclk domain, pin levels resolved by the link interface
// Notes:   hold checks count low samples of the reset pin
`timescale 1ns/10ps
`default_nettype none
module rsc_link_chk
  import rsc_pkg::*;
#(
  parameter int POR_CYC = POR_HOLD_CYC // power-on hold cycles
)
(
  input wire logic               mclk,         // system clock
  input wire logic               arst_n,       // async reset
  input wire logic               reset_pin_n,  // board reset pin
  input wire logic [NUM_TMR-1:0] tmr_dev_oe,   // timer pin enables
  input wire logic [STRAP_W-1:0] brd_strap_o,  // resistor level
  input wire logic [STRAP_W-1:0] brd_strap_oe, // resistor fitted
  input wire logic               clk_out,      // output clock
  input wire logic               clk_out_oe    // output clock enable
);
  logic [15:0] low_q;
  logic        por_q;

  // low samples seen since the pin last was high
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      low_q <= 16'h0000;
    end else begin
      low_q <= reset_pin_n ? 16'h0000 : low_q + 16'h0001;
    end
  end
  // first release after power-on needs the longer hold
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      por_q <= 1'b1;
    end else if (reset_pin_n) begin
      por_q <= 1'b0;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  property p_por_hold;
    $rose(reset_pin_n) && por_q |-> low_q >= POR_CYC;
  endproperty
  property p_run_hold;
    $rose(reset_pin_n) && !por_q |-> low_q >= RST_HOLD_CYC;
  endproperty
  property p_hiz;
    !reset_pin_n ##1 !reset_pin_n |-> tmr_dev_oe == 4'h0 && !clk_out_oe;
  endproperty
  property p_clk_oe;
    $rose(reset_pin_n) |=> clk_out_oe;
  endproperty
  property p_clk_hi;
    disable iff (!arst_n || !reset_pin_n)
      $rose(clk_out) |-> clk_out[*5] ##1 !clk_out;
  endproperty
  property p_clk_lo;
    disable iff (!arst_n || !reset_pin_n)
      $fell(clk_out) |-> (!clk_out)[*5] ##1 clk_out;
  endproperty
  property p_static;
    $rose(reset_pin_n) |-> $stable(brd_strap_o) && $stable(brd_strap_oe);
  endproperty
  property p_latch_undriven;
    $rose(reset_pin_n) |-> tmr_dev_oe == 4'h0;
  endproperty

  a_por_hold: assert property (p_por_hold)
    else $error("power-on reset too short");
  a_run_hold: assert property (p_run_hold)
    else $error("runtime reset too short");
  a_hiz: assert property (p_hiz)
    else $error("pin driven during reset");
  a_clk_oe: assert property (p_clk_oe)
    else $error("clock output not enabled");
  a_clk_hi: assert property (p_clk_hi)
    else $error("clock high phase wrong");
  a_clk_lo: assert property (p_clk_lo)
    else $error("clock low phase wrong");
  a_static: assert property (p_static)
    else $error("straps moved at latch");
  a_latch_undriven: assert property (p_latch_undriven)
    else $error("timer pin driven at latch");

  c_release: cover property ($rose(reset_pin_n));
  c_run_reset: cover property ($fell(reset_pin_n) && !por_q);
  c_tmr_drive: cover property (tmr_dev_oe == 4'hF);
endmodule // rsc_link_chk
`default_nettype wire

/* File: test/reset_strap_capture_bench.sv */
// Purpose: self-checking bench for reset strap capture, both ends
// Assumes: power-on hold shortened through POR_CYC
// Notes:   board and device face each other on one link interface
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) \
  begin tests_run++; if ((g) !== (e)) begin n_errors++; \
  $display("FAIL %s exp %0h got %0h", nm, e, g); end end
module reset_strap_capture_bench;
  import rsc_pkg::*;
  localparam int POR = 20; // short hold keeps the run brief
  logic                    mclk, arst_n, reset_req, spi_irq, sec_host_req;
  logic [STRAP_W-1:0]      strap_fit, strap_val;
  logic [NUM_TMR-1:0][2:0] tmr_fn;
  logic [NUM_TMR-1:0]      tsn_out, legacy_out, gpio_out, gpio_oe;
  logic [NUM_TMR-1:0]      general_io_in_q;
  logic [1:0]              ptp_out;
  logic                    cfg_valid_q, host_is_spi_q, port_valid_q;
  logic                    cfg_invalid_q, drive_high_q, rx_delay_q;
  logic                    tx_delay_q, sec_host_on_q, in_reset_q;
  rsc_spi_mode_t           spi_mode_q;
  logic [2:0]              host_port_q;
  logic [3:0]              iface_code_q;
  logic [1:0]              capture_evt;
  int                      n_errors = 0;
  int                      tests_run = 0;

  rsc_link_if link ();
  rsc_device u_rsc_device (.mclk, .arst_n, .link, .tmr_fn, .tsn_out,
    .legacy_out, .ptp_out, .spi_irq, .gpio_out, .gpio_oe, .sec_host_req,
    .cfg_valid_q, .host_is_spi_q, .spi_mode_q, .host_port_q, .port_valid_q,
    .cfg_invalid_q, .drive_high_q, .iface_code_q, .rx_delay_q, .tx_delay_q,
    .sec_host_on_q, .capture_evt, .general_io_in_q);
  rsc_board #(.POR_CYC(POR)) u_rsc_board (.mclk, .arst_n, .link,
    .reset_req, .strap_fit, .strap_val, .in_reset_q);
  rsc_link_chk #(.POR_CYC(POR)) u_rsc_link_chk (.mclk, .arst_n,
    .reset_pin_n(link.reset_pin_n), .tmr_dev_oe(link.tmr_dev_oe),
    .brd_strap_o(link.brd_strap_o), .brd_strap_oe(link.brd_strap_oe),
    .clk_out(link.clk_out), .clk_out_oe(link.clk_out_oe));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic wait_valid();
    int n;
    n = 0;
    while (cfg_valid_q !== 1'b1 && n < 3000) begin
      @(negedge mclk);
      n++;
    end
    `CHK("cfg_valid", 1'b1, cfg_valid_q)
  endtask

  // pulse a runtime reset with new straps; device pins must float
  task automatic do_reset(input logic [7:0] fit, input logic [7:0] val);
    @(negedge mclk);
    strap_fit = fit;
    strap_val = val;
    reset_req = 1'b1;
    @(negedge mclk);
    reset_req = 1'b0;
    repeat (4) @(negedge mclk);
    `CHK("oe_in_reset", 5'h00, {link.clk_out_oe, link.tmr_dev_oe})
    `CHK("valid_in_reset", 1'b0, cfg_valid_q)
    `CHK("in_reset", 1'b1, in_reset_q)
    wait_valid();
    `CHK("out_of_reset", 1'b0, in_reset_q)
  endtask

  task automatic chk_cfg(input logic s, input logic [2:0] p,
                         input logic pv, input logic inv, input logic ds);
    `CHK("host_is_spi", s, host_is_spi_q)
    `CHK("host_port", p, host_port_q)
    `CHK("port_valid", pv, port_valid_q)
    `CHK("cfg_invalid", inv, cfg_invalid_q)
    `CHK("drive_high", ds, drive_high_q)
  endtask

  task automatic tmr_step(input logic [11:0] fn, input logic [3:0] eoe,
                          input logic [3:0] eo);
    @(negedge mclk);
    tmr_fn = fn;
    repeat (2) @(negedge mclk);
    `CHK("tmr_oe", eoe, link.tmr_dev_oe)
    `CHK("tmr_o", eo, link.tmr_dev_o & link.tmr_dev_oe)
  endtask

  task automatic t_default();
    chk_cfg(1'b1, 3'h0, 1'b0, 1'b0, 1'b0);
    `CHK("spi_mode", SPI_SINGLE, spi_mode_q)
    `CHK("iface_code", 4'h3, iface_code_q)
    `CHK("por_done", 1'b0, in_reset_q)
    $display("test default done");
  endtask

  task automatic t_timers();
    tmr_step({TFN_IRQ,TFN_PTP,TFN_PTP,TFN_IRQ},4'h5,4'h5);
    tmr_step({4{TFN_TSN}}, 4'hF, 4'hA);
    tmr_step({4{TFN_LEGACY}}, 4'hF, 4'h5);
    tmr_step({4{TFN_CAPTURE}}, 4'h0, 4'h0);
    tmr_step({4{TFN_GPIO}}, 4'hF, 4'h9);
    `CHK("general_io_in", 4'h9, general_io_in_q)
    // pins now differ from the latched straps; config must not follow
    `CHK("iface_hold", 4'h3, iface_code_q)
    `CHK("spi_hold", 1'b1, host_is_spi_q)
    $display("test timers done");
  endtask

  task automatic t_sec();
    @(negedge mclk);
    sec_host_req = 1'b1;
    repeat (2) @(negedge mclk);
    `CHK("sec_host_on", 1'b1, sec_host_on_q)
    sec_host_req = 1'b0;
    repeat (2) @(negedge mclk);
    `CHK("sec_host_off", 1'b0, sec_host_on_q)
    $display("test second host done");
  endtask

  task automatic t_ports();
    logic [2:0] p;
    for (int i = 0; i < 8; i++) begin
      p = 3'(i);
      do_reset(8'hFF, {p, p[1], p[0] ? 4'h5 : 4'h0});
      chk_cfg(1'b0, p, p <= 3'h5, p >= 3'h6, p[1]);
      `CHK("rx_delay", p[0], rx_delay_q)
      `CHK("tx_delay", p[0], tx_delay_q)
    end
    $display("test ports done");
  endtask

  task automatic t_spi();
    logic [1:0]    b;
    rsc_spi_mode_t md [4];
    logic [3:0]    dsv;
    md = '{SPI_SINGLE, SPI_DUAL, SPI_QUAD, SPI_QUAD};
    dsv = 4'h9;
    for (int i = 0; i < 4; i++) begin
      b = 2'(i);
      do_reset(8'hFF, {~b[0], 2'h3, 1'b1, b[0], b[1], 2'h3});
      chk_cfg(1'b1, 3'h0, 1'b0, 1'b0, dsv[b]);
      `CHK("spi_mode", md[i], spi_mode_q)
    end
    $display("test spi modes done");
  endtask

  // gpio holds pin 2 low over a high strap; handing the pin to capture
  // releases it, and that rise must give exactly one pulse
  task automatic t_capture();
    tmr_step({4{TFN_GPIO}}, 4'hF, 4'h9);
    tmr_fn = {4{TFN_CAPTURE}};
    repeat (2) @(negedge mclk);
    `CHK("capture_pulse", 2'h1, capture_evt)
    @(negedge mclk);
    `CHK("capture_end", 2'h0, capture_evt)
    $display("test capture done");
  endtask

  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end

  initial begin
    repeat (60000) @(posedge mclk);
    n_errors++;
    $display("watchdog expired");
    finish_test();
  end

  initial begin
    arst_n = 1'b0;
    reset_req = 1'b0;
    strap_fit = 8'h00;
    strap_val = 8'h00;
    tmr_fn = '0;
    tsn_out = 4'hA;
    legacy_out = 4'h5;
    gpio_out = 4'h9;
    gpio_oe = 4'hF;
    ptp_out = 2'h3;
    spi_irq = 1'b1;
    sec_host_req = 1'b0;
    repeat (6) @(posedge mclk);
    @(negedge mclk);
    arst_n = 1'b1;
    wait_valid();
    t_default();
    t_timers();
    t_sec();
    t_ports();
    t_spi();
    t_capture();
    finish_test();
  end
endmodule // reset_strap_capture_bench
`default_nettype wire
